// *** mocl_pkg.sv ***
package mocl_pkg;
    localparam int CUR_W = 16;
    localparam int ACC_W = 48;
    localparam int DUR_W = 16;

    localparam logic [7:0] OFF_PEAK = 8'h00;
    localparam logic [7:0] OFF_RATED = 8'h04;
    localparam logic [7:0] OFF_DUR = 8'h08;
    localparam logic [7:0] OFF_MODE = 8'h0c;
    localparam logic [7:0] OFF_THRESH = 8'h10;
    localparam logic [7:0] OFF_ACC = 8'h14;
    localparam logic [7:0] OFF_LIMIT = 8'h18;
    localparam logic [7:0] OFF_STATUS = 8'h1c;
    localparam logic [7:0] OFF_MEAS = 8'h20;

    localparam int MODE_CLOSED_BIT = 0;
    localparam logic [CUR_W-1:0] PEAK_RST = 16'h0000;
    localparam logic [CUR_W-1:0] RATED_RST = 16'h0000;
    localparam logic [DUR_W-1:0] DUR_RST = 16'h0000;
    localparam logic [31:0] MODE_RST = 32'h0000_0000;

    // Integration step of one millisecond
    localparam int CLK_HZ = 50_000_000;
    localparam int STEP_US = 1000;
    localparam int STEP_CYC = CLK_HZ / 1_000_000 * STEP_US;
    localparam int STEP_CW = 16;

    typedef struct packed {
        logic [CUR_W-1:0] peak;
        logic [CUR_W-1:0] rated;
        logic [DUR_W-1:0] dur_ms;
        logic closed_loop;
    } mocl_cfg_t;

    typedef struct packed {
        logic [ACC_W-1:0] thresh;
        logic [ACC_W-1:0] acc;
        logic [CUR_W-1:0] limit;
        logic active;
    } mocl_stat_t;
endpackage

// *** mocl_tick.sv ***
module mocl_tick #(
    parameter int PERIOD = mocl_pkg::STEP_CYC
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    output logic o_tick
);
    import mocl_pkg::*;
    logic [STEP_CW-1:0] cnt_q, cnt_d;
    logic tick_d;

    always_comb begin
        tick_d = (cnt_q == STEP_CW'(PERIOD - 1));
        cnt_d = tick_d ? '0 : cnt_q + 1'b1;
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt_q <= '0;
            o_tick <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            o_tick <= tick_d;
        end
    end
endmodule // mocl_tick

// *** mocl_wb_regs.sv ***
module mocl_wb_regs (
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    input wire mocl_pkg::mocl_stat_t i_stat,
    input wire logic [mocl_pkg::CUR_W-1:0] i_meas,
    output logic o_wb_ack,
    output logic [31:0] o_wb_dat,
    output mocl_pkg::mocl_cfg_t o_cfg
);
    import mocl_pkg::*;
    logic [CUR_W-1:0] peak_q, peak_d, rated_q, rated_d;
    logic [DUR_W-1:0] dur_q, dur_d;
    logic [31:0] mode_q, mode_d, rdat_d, wmask;
    logic ack_d, wr;

    always_comb begin
        wmask = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}}, {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
        ack_d = i_wb_cyc && i_wb_stb && !o_wb_ack;
        wr = ack_d && i_wb_we;
        peak_d = peak_q;
        rated_d = rated_q;
        dur_d = dur_q;
        mode_d = mode_q;
        rdat_d = 32'h0000_0000;
        case (i_wb_adr)
            OFF_PEAK: begin
                rdat_d = {16'h0000, peak_q};
                if (wr) peak_d = (peak_q & ~wmask[15:0]) | (i_wb_dat[15:0] & wmask[15:0]);
            end
            OFF_RATED: begin
                rdat_d = {16'h0000, rated_q};
                if (wr) rated_d = (rated_q & ~wmask[15:0]) | (i_wb_dat[15:0] & wmask[15:0]);
            end
            OFF_DUR: begin
                rdat_d = {16'h0000, dur_q};
                if (wr) dur_d = (dur_q & ~wmask[15:0]) | (i_wb_dat[15:0] & wmask[15:0]);
            end
            OFF_MODE: begin
                rdat_d = mode_q;
                if (wr) mode_d = (mode_q & ~wmask) | (i_wb_dat & wmask);
            end
            OFF_THRESH: rdat_d = i_stat.thresh[31:0];
            OFF_ACC: rdat_d = i_stat.acc[31:0];
            OFF_LIMIT: rdat_d = {16'h0000, i_stat.limit};
            OFF_STATUS: rdat_d = {31'h0, i_stat.active};
            OFF_MEAS: rdat_d = {16'h0000, i_meas};
            default: rdat_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            peak_q <= PEAK_RST;
            rated_q <= RATED_RST;
            dur_q <= DUR_RST;
            mode_q <= MODE_RST;
            o_wb_ack <= 1'b0;
            o_wb_dat <= 32'h0000_0000;
        end else begin
            peak_q <= peak_d;
            rated_q <= rated_d;
            dur_q <= dur_d;
            mode_q <= mode_d;
            o_wb_ack <= ack_d;
            o_wb_dat <= ack_d ? rdat_d : 32'h0000_0000;
        end
    end

    assign o_cfg = '{peak: peak_q, rated: rated_q, dur_ms: dur_q, closed_loop: mode_q[MODE_CLOSED_BIT]};
endmodule // mocl_wb_regs

// *** mocl_overload.sv ***
// Operation
// - Full overload limiting works only while the closed-loop bit 0 of the drive mode register is one.
// - With protection configured but open loop selected, the limit is clamped to the rated current.
// - A readable threshold in mA*mA*ms units decides between peak and rated current.
// - A readable accumulated value is compared each cycle with the threshold.
// - The presently applied current limit is readable.
// - Status reads 0 when protection is inactive and 1 when active.
// - Activation needs closed loop, peak above rated and a nonzero duration.
// - When any activation condition fails, protection stays inactive and reports so.
// - The limit is derived from rated, peak and duration as (peak^2 - rated^2) * duration.
// - Peak current is allowed until the accumulated value reaches the limit, then rated at once.
// - Higher drawn current makes the accumulated value grow faster.
module mocl_overload #(
    parameter int STEP_PERIOD = mocl_pkg::STEP_CYC
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    input wire logic [mocl_pkg::CUR_W-1:0] i_meas_current,
    output logic o_wb_ack,
    output logic [31:0] o_wb_dat,
    output logic [mocl_pkg::CUR_W-1:0] o_current_limit,
    output logic o_limit_active
);
    import mocl_pkg::*;

    mocl_cfg_t cfg;
    mocl_stat_t stat;
    logic tick;
    logic [ACC_W-1:0] acc_q, acc_d, thresh_q, thresh_d;
    logic [CUR_W-1:0] lim_d;
    logic active_q, active_d, lim_act_d, configured;
    logic [2*CUR_W-1:0] meas_sq, rated_sq, peak_sq;
    logic [ACC_W-1:0] rise, fall;

    mocl_wb_regs u_regs (
        .i_sys_clk(i_sys_clk),
        .i_rst_b(i_rst_b),
        .i_wb_cyc(i_wb_cyc),
        .i_wb_stb(i_wb_stb),
        .i_wb_we(i_wb_we),
        .i_wb_adr(i_wb_adr),
        .i_wb_sel(i_wb_sel),
        .i_wb_dat(i_wb_dat),
        .i_stat(stat),
        .i_meas(i_meas_current),
        .o_wb_ack(o_wb_ack),
        .o_wb_dat(o_wb_dat),
        .o_cfg(cfg)
    );

    mocl_tick #(.PERIOD(STEP_PERIOD)) u_tick (
        .i_sys_clk(i_sys_clk),
        .i_rst_b(i_rst_b),
        .o_tick(tick)
    );

    always_comb begin
        meas_sq = i_meas_current * i_meas_current;
        rated_sq = cfg.rated * cfg.rated;
        peak_sq = cfg.peak * cfg.peak;
        configured = (cfg.peak > cfg.rated) && (cfg.dur_ms != '0);
        active_d = configured && cfg.closed_loop;
        thresh_d = ACC_W'(peak_sq - rated_sq) * ACC_W'(cfg.dur_ms);
        rise = ACC_W'(meas_sq) - ACC_W'(rated_sq);
        fall = ACC_W'(rated_sq) - ACC_W'(meas_sq);
        acc_d = acc_q;
        if (!active_q) begin
            acc_d = '0;
        end else if (tick) begin
            if (meas_sq >= rated_sq) begin
                acc_d = (acc_q + rise < acc_q) ? '1 : acc_q + rise;
            end else begin
                acc_d = (acc_q > fall) ? acc_q - fall : '0;
            end
        end
        lim_act_d = 1'b0;
        if (active_q) begin
            if (acc_q >= thresh_q) begin
                lim_d = cfg.rated;
                lim_act_d = 1'b1;
            end else begin
                lim_d = cfg.peak;
            end
        end else if (configured) begin
            lim_d = cfg.rated;
            lim_act_d = 1'b1;
        end else begin
            lim_d = cfg.peak;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            acc_q <= '0;
            thresh_q <= '0;
            active_q <= 1'b0;
            o_current_limit <= '0;
            o_limit_active <= 1'b0;
        end else begin
            acc_q <= acc_d;
            thresh_q <= thresh_d;
            active_q <= active_d;
            o_current_limit <= lim_d;
            o_limit_active <= lim_act_d;
        end
    end

    assign stat = '{thresh: thresh_q, acc: acc_q, limit: o_current_limit, active: active_q};
endmodule // mocl_overload

// *** mocl_overload_sva.sv ***
module mocl_overload_sva (
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    input wire logic [mocl_pkg::CUR_W-1:0] i_meas_current,
    input wire logic o_wb_ack,
    input wire logic [31:0] o_wb_dat,
    input wire logic [mocl_pkg::CUR_W-1:0] o_current_limit,
    input wire logic o_limit_active
);
    timeunit 1ns;
    timeprecision 1ps;
    import mocl_pkg::*;
    logic rd_req;
    assign rd_req = i_wb_cyc && i_wb_stb && !i_wb_we && !o_wb_ack;
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_b);
    a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("ack held too long");
    a_ack_answer: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
        else $error("ack missing");
    a_ack_cause: assert property (o_wb_ack |-> $past(i_wb_stb))
        else $error("ack without request");
    a_dat_idle: assert property (!o_wb_ack |-> o_wb_dat == 32'h0)
        else $error("read data outside ack");
    a_meas_read: assert property (rd_req && i_wb_adr == OFF_MEAS |=> o_wb_dat == {16'h0, $past(i_meas_current)})
        else $error("measured current readback");
    a_unmapped_zero: assert property (rd_req && i_wb_adr > OFF_MEAS |=> o_wb_dat == 32'h0)
        else $error("unmapped read not zero");
    a_status_bits: assert property (rd_req && i_wb_adr == OFF_STATUS |=> o_wb_dat[31:1] == 31'h0)
        else $error("status upper bits set");
    // Clamp by accumulation only; config writes may legally raise the limit
    a_clamp_drop: assert property ($rose(o_limit_active) && !$past(o_wb_ack) && !$past(o_wb_ack, 2) |->
        o_current_limit < $past(o_current_limit))
        else $error("limit did not drop on clamp");
endmodule // mocl_overload_sva

// *** mocl_motor_model.sv ***
module mocl_motor_model (
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire logic [mocl_pkg::CUR_W-1:0] i_limit,
    input wire logic [mocl_pkg::CUR_W-1:0] i_demand,
    output logic [mocl_pkg::CUR_W-1:0] o_meas
);
    timeunit 1ns;
    timeprecision 1ps;
    import mocl_pkg::*;
    // Current loop follows demand, never above the applied limit
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_meas <= '0;
        end else begin
            o_meas <= (i_demand > i_limit) ? i_limit : i_demand;
        end
    end
endmodule // mocl_motor_model

// *** testbench.sv ***
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import mocl_pkg::*;
    logic i_sys_clk = 1'b0, i_rst_b = 1'b0, i_wb_cyc = 1'b0, i_wb_stb = 1'b0, i_wb_we = 1'b0;
    logic [7:0] i_wb_adr = 8'h00;
    logic [3:0] i_wb_sel = 4'hf;
    logic [31:0] i_wb_dat = 32'h0, o_wb_dat, seed = 32'h66860c6a;
    logic [15:0] i_meas_current, o_current_limit, demand = 16'h0;
    logic o_wb_ack, o_limit_active;
    int num_errors = 0, num_checks = 0;
    // Short integration step keeps the run brief
    localparam int TB_STEP = 64;
    always #10 i_sys_clk = ~i_sys_clk;
    mocl_overload #(.STEP_PERIOD(TB_STEP)) DUT (.i_sys_clk, .i_rst_b, .i_wb_cyc, .i_wb_stb, .i_wb_we,
        .i_wb_adr, .i_wb_sel, .i_wb_dat, .i_meas_current, .o_wb_ack, .o_wb_dat, .o_current_limit, .o_limit_active);
    mocl_motor_model u_motor (.i_sys_clk, .i_rst_b, .i_limit(o_current_limit), .i_demand(demand),
        .o_meas(i_meas_current));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Overload limit in mA*mA*ms
    function automatic logic [47:0] thr(input logic [15:0] p, input logic [15:0] r, input logic [15:0] d);
        return (48'(p) * 48'(p) - 48'(r) * 48'(r)) * 48'(d);
    endfunction
    // One integration step, floored at zero
    function automatic logic [47:0] step(input logic [47:0] a, input logic [15:0] m, input logic [15:0] r);
        logic [47:0] ms, rs;
        ms = 48'(m) * 48'(m);
        rs = 48'(r) * 48'(r);
        return (ms >= rs) ? a + (ms - rs) : ((a > rs - ms) ? a - (rs - ms) : 48'h0);
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input string nm, input logic [31:0] e);
        @(posedge i_sys_clk);
        i_wb_cyc <= 1'b1;
        i_wb_stb <= 1'b1;
        i_wb_we <= w;
        i_wb_adr <= a;
        i_wb_dat <= d;
        do begin
            @(posedge i_sys_clk);
        end while (o_wb_ack !== 1'b1);
        if (!w) chk(nm, e, o_wb_dat);
        i_wb_cyc <= 1'b0;
        i_wb_stb <= 1'b0;
    endtask
    // Bounded wait for the clamp flag; a timeout shows as a mismatch
    task automatic wait_act(input logic v, input string nm);
        int n;
        n = 0;
        while (o_limit_active !== v && n < 4 * TB_STEP) begin
            @(posedge i_sys_clk);
            n++;
        end
        chk(nm, {31'h0, v}, {31'h0, o_limit_active});
    endtask
    task automatic results;
        $display("errors %0d checks %0d", num_errors, num_checks);
        if (num_errors == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        logic [15:0] pk, rt, du;
        logic cl, ok;
        logic [47:0] th, ac;
        repeat (6) @(posedge i_sys_clk);
        i_rst_b <= 1'b1;
        wb(0, OFF_PEAK, 0, "peak", 0);
        chk("reset limit", 0, {16'h0, o_current_limit});
        wb(0, 8'h40, 0, "unmapped", 0);
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            pk = seed[15:0];
            seed = lfsr(seed);
            rt = (i == 0) ? pk : seed[15:0];
            du = (i == 1) ? 16'h0 : {12'h0, seed[19:16]};
            cl = seed[20] | (i < 2);
            ok = pk > rt && du != 16'h0;
            th = thr(pk, rt, du);
            wb(1, OFF_PEAK, {16'h0, pk}, "", 0);
            wb(1, OFF_RATED, {16'h0, rt}, "", 0);
            wb(1, OFF_DUR, {16'h0, du}, "", 0);
            wb(1, OFF_MODE, {31'h0, cl}, "", 0);
            wb(0, OFF_STATUS, 0, "status", {31'h0, cl & ok});
            if (cl & ok) wb(0, OFF_THRESH, 0, "threshold", th[31:0]);
            wb(0, OFF_LIMIT, 0, "limit", {16'h0, (ok & !cl) ? rt : pk});
            chk("active", {31'h0, ok & !cl}, {31'h0, o_limit_active});
        end
        // Byte-masked write keeps the upper byte
        i_wb_sel <= 4'h1;
        wb(1, OFF_RATED, 32'h0000_ab12, "", 0);
        i_wb_sel <= 4'hf;
        wb(0, OFF_RATED, 0, "rated byte", {16'h0, rt[15:8], 8'h12});
        wb(0, OFF_MEAS, 0, "meas idle", 0);
        wb(1, OFF_PEAK, 2000, "", 0);
        wb(1, OFF_RATED, 1000, "", 0);
        wb(1, OFF_DUR, 1, "", 0);
        wb(1, OFF_MODE, 1, "", 0);
        wb(1, OFF_THRESH, 32'hffffffff, "", 0);
        th = thr(16'd2000, 16'd1000, 16'd1);
        wb(0, OFF_THRESH, 0, "threshold", th[31:0]);
        demand <= 16'd3000;
        repeat (2) @(posedge i_sys_clk);
        chk("meas", 2000, {16'h0, i_meas_current});
        wait_act(1'b1, "clamp");
        ac = step(48'h0, 16'd2000, 16'd1000);
        chk("limit pin", 1000, {16'h0, o_current_limit});
        wb(0, OFF_LIMIT, 0, "limit", 1000);
        wb(0, OFF_ACC, 0, "accum", ac[31:0]);
        wb(0, OFF_STATUS, 0, "status", 1);
        wb(0, OFF_MEAS, 0, "meas clamped", 1000);
        // Below rated the value drains and peak comes back
        demand <= 16'd0;
        wait_act(1'b0, "release");
        ac = step(ac, 16'd0, 16'd1000);
        wb(0, OFF_LIMIT, 0, "limit", 2000);
        wb(0, OFF_ACC, 0, "accum", ac[31:0]);
        // Smaller excess grows more slowly than peak did
        demand <= 16'd1500;
        wait_act(1'b1, "clamp mid");
        ac = step(ac, 16'd1500, 16'd1000);
        wb(0, OFF_ACC, 0, "accum", ac[31:0]);
        results();
    end
    initial begin
        repeat (20000) @(posedge i_sys_clk);
        num_errors++;
        results();
    end
endmodule // testbench

bind mocl_overload mocl_overload_sva u_sva (.i_sys_clk, .i_rst_b, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr,
    .i_wb_sel, .i_wb_dat, .i_meas_current, .o_wb_ack, .o_wb_dat, .o_current_limit, .o_limit_active);
